// ### hw/tpd_pkg.sv
package tpd_pkg;

    localparam int TPD_WIDTH = 8;
    localparam logic [7:0] TPD_STRAP_RESET = 8'h00;
    localparam logic [2:0] TPD_MODE_QUIET = 3'h0;
    localparam logic [2:0] TPD_MODE_CLOCK = 3'h2;

    localparam int TPD_CLK_MHZ = 100;
    // debug clock targets in kHz
    localparam int TPD_FAST_KHZ = 60000;
    localparam int TPD_SLOW_KHZ = 7500;
    localparam int TPD_VAR_MIN_KHZ = 700;
    localparam int TPD_VAR_MAX_KHZ = 22500;
    // half periods in cycles, rounded down (variable minimum rounded up), never below one
    localparam int TPD_FAST_HALF_RAW = (TPD_CLK_MHZ * 1000) / (2 * TPD_FAST_KHZ);
    localparam int TPD_FAST_HALF = (TPD_FAST_HALF_RAW < 1) ? 1 : TPD_FAST_HALF_RAW;
    localparam int TPD_SLOW_HALF = (TPD_CLK_MHZ * 1000) / (2 * TPD_SLOW_KHZ);
    localparam int TPD_VAR_HALF_MIN = (TPD_CLK_MHZ * 1000 + 2 * TPD_VAR_MAX_KHZ - 1)
                                      / (2 * TPD_VAR_MAX_KHZ);
    localparam int TPD_VAR_HALF_MAX = (TPD_CLK_MHZ * 1000) / (2 * TPD_VAR_MIN_KHZ);
    localparam int TPD_DIV_WIDTH = 8;
    localparam logic [7:0] TPD_VAR_HALF_RESET = 8'h04;

    // per-pin output source selection
    typedef enum logic [1:0] {
        TPD_SRC_HIZ,
        TPD_SRC_LOW,
        TPD_SRC_HIGH,
        TPD_SRC_CLOCK
    } tpd_src_type;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } tpd_pins_type;

    typedef struct packed {
        logic valid;
        logic [7:0] pin;
        tpd_src_type src;
        logic [7:0] var_half;
    } tpd_sel_type;

endpackage : tpd_pkg

// ### hw/tpd_clkdiv.sv
`timescale 1ns/1ps
module tpd_clkdiv
    import tpd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic [TPD_DIV_WIDTH-1:0] half,
    // square wave
    output logic clk_out
);
    logic [TPD_DIV_WIDTH-1:0] count;
    wire logic at_end = (count >= half - 8'h01);

    always_ff @(posedge clk)
    begin
        if (!rst_n || !run)
        begin
            count <= 8'h00;
            clk_out <= 1'b0;
        end
        else if (at_end)
        begin
            count <= 8'h00;
            clk_out <= ~clk_out;
        end
        else
        begin
            count <= count + 8'h01;
        end
    end
endmodule : tpd_clkdiv

// ### hw/tpd_top.sv
// What this block does
// - all eight debug test points are inputs while reset is low; after release only those whose source is not HIZ drive.
// - the pin levels are captured at reset release and select the mode until the next reset.
// - outside clock-debug mode the captured default pattern keeps every test point high impedance.
// - straps are sampled only on the reset low-to-high transition; later changes are ignored.
// - clock-debug mode drives 50 MHz on 0, 0.7-16.7 MHz on 2, 8.3 MHz on 7, 3/5/6 high, 4 low.
// - software may reprogram each test point's output selection at any time after the straps are captured.
`timescale 1ns/1ps
module tpd_top
    import tpd_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // debug test point pins
    input wire logic [7:0] DEBUG_TEST_POINT_IN,
    output logic [7:0] DEBUG_TEST_POINT_OUT,
    output logic [7:0] DEBUG_TEST_POINT_OE,
    // software selection port
    input wire tpd_sel_type SEL,
    // status
    output logic [7:0] STRAP_VALUE,
    output logic STRAP_VALID
);
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic rst_meta;
    logic rst_sync;
    logic running;
    logic [7:0] strap;
    logic strap_done;
    logic [1:0] src_sel [8];
    logic [7:0] var_half;
    tpd_pins_type pins;

    // strap pins pass two flops first
    always_ff @(posedge CLK)
    begin
        pin_meta <= DEBUG_TEST_POINT_IN;
        pin_sync <= pin_meta;
    end

    // release of reset is resynchronised so the capture lands on the third clock edge after it
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    wire logic capture_now = rst_sync && !strap_done;

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            strap <= TPD_STRAP_RESET;
            strap_done <= 1'b0;
        end
        else if (capture_now)
        begin
            strap <= pin_sync;
            strap_done <= 1'b1;
        end
    end

    wire logic [2:0] mode = strap[2:0];
    wire logic clock_mode = (mode == TPD_MODE_CLOCK);

    // default source per pin from the strap mode
    function automatic logic [1:0] default_src(input logic clk_mode, input int idx);
        logic [1:0] s;
        s = TPD_SRC_HIZ;
        if (clk_mode)
        begin
            case (idx)
                0, 2, 7: s = TPD_SRC_CLOCK;
                3, 5, 6: s = TPD_SRC_HIGH;
                4: s = TPD_SRC_LOW;
                default: s = TPD_SRC_HIZ;
            endcase
        end
        return s;
    endfunction : default_src

    wire logic sel_write = SEL.valid && strap_done;

    generate
        for (genvar i = 0; i < TPD_WIDTH; i++)
        begin : g_sel
            always_ff @(posedge CLK)
            begin
                if (!RESET_N)
                    src_sel[i] <= TPD_SRC_HIZ;
                else if (capture_now)
                    src_sel[i] <= default_src(pin_sync[2:0] == TPD_MODE_CLOCK, i);
                else if (sel_write && SEL.pin[i])
                    src_sel[i] <= SEL.src;
            end
        end
    endgenerate

    // half periods outside the allowed band for pin 2 are refused
    wire logic var_ok = (SEL.var_half >= 8'(TPD_VAR_HALF_MIN))
        && (SEL.var_half <= 8'(TPD_VAR_HALF_MAX));

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            var_half <= TPD_VAR_HALF_RESET;
        else if (sel_write && var_ok)
            var_half <= SEL.var_half;
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            running <= 1'b0;
        else
            running <= strap_done;
    end

    // debug clocks: pin 0 fast, pin 2 variable, pin 7 slow
    logic clk_fast;
    logic clk_var;
    logic clk_slow;

    tpd_clkdiv u_fast (
        .clk(CLK),
        .rst_n(RESET_N),
        .run(running),
        .half(8'(TPD_FAST_HALF)),
        .clk_out(clk_fast)
    );
    tpd_clkdiv u_var (
        .clk(CLK),
        .rst_n(RESET_N),
        .run(running),
        .half(var_half),
        .clk_out(clk_var)
    );
    tpd_clkdiv u_slow (
        .clk(CLK),
        .rst_n(RESET_N),
        .run(running),
        .half(8'(TPD_SLOW_HALF)),
        .clk_out(clk_slow)
    );

    wire logic [7:0] clk_bus = {clk_slow, 4'h0, clk_var, 1'b0, clk_fast};

    always_comb
    begin
        for (int k = 0; k < TPD_WIDTH; k++)
        begin
            pins.oe[k] = strap_done && (src_sel[k] != TPD_SRC_HIZ);
            case (src_sel[k])
                TPD_SRC_HIGH: pins.out[k] = 1'b1;
                TPD_SRC_CLOCK: pins.out[k] = clk_bus[k];
                default: pins.out[k] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            DEBUG_TEST_POINT_OUT <= 8'h00;
            DEBUG_TEST_POINT_OE <= 8'h00;
            STRAP_VALUE <= 8'h00;
            STRAP_VALID <= 1'b0;
        end
        else
        begin
            DEBUG_TEST_POINT_OUT <= pins.out;
            DEBUG_TEST_POINT_OE <= pins.oe;
            STRAP_VALUE <= strap;
            STRAP_VALID <= strap_done;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    property p_inputs_in_reset;
        $rose(RESET_N) |-> (DEBUG_TEST_POINT_OE == 8'h00) [*2];
    endproperty
    a_inputs_in_reset: assert property (p_inputs_in_reset) else $error("pins driven after reset");

    property p_strap_hold;
        STRAP_VALID && $past(STRAP_VALID) |-> $stable(STRAP_VALUE);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");

    property p_capture_time;
        $rose(RESET_N) |-> ##3 strap_done;
    endproperty
    a_capture_time: assert property (p_capture_time) else $error("strap not captured in time");

    property p_capture_value;
        capture_now |=> strap == $past(pin_sync);
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("wrong strap captured");

    property p_quiet_hiz;
        capture_now && pin_sync[2:0] == TPD_MODE_QUIET
            |-> ##2 DEBUG_TEST_POINT_OE == 8'h00;
    endproperty
    a_quiet_hiz: assert property (p_quiet_hiz) else $error("quiet mode drives pins");

    property p_clock_levels;
        capture_now && pin_sync[2:0] == TPD_MODE_CLOCK ##1 !SEL.valid [*2]
            |=> DEBUG_TEST_POINT_OE == 8'hfd && DEBUG_TEST_POINT_OUT[6:3] == 4'hd;
    endproperty
    a_clock_levels: assert property (p_clock_levels) else $error("clock mode levels wrong");

    property p_sw_select;
        sel_write && SEL.pin[1] && SEL.src == TPD_SRC_HIGH
            |-> ##2 DEBUG_TEST_POINT_OE[1] && DEBUG_TEST_POINT_OUT[1];
    endproperty
    a_sw_select: assert property (p_sw_select) else $error("software select ignored");

    property p_fast_toggle;
        running && src_sel[0] == TPD_SRC_CLOCK && $past(src_sel[0]) == TPD_SRC_CLOCK
            && $past(running, 2) |-> ##1 DEBUG_TEST_POINT_OUT[0] != $past(DEBUG_TEST_POINT_OUT[0]);
    endproperty
    a_fast_toggle: assert property (p_fast_toggle) else $error("fast clock not toggling");

    c_quiet: cover property (capture_now && pin_sync[2:0] == TPD_MODE_QUIET);
    c_clock: cover property (capture_now && pin_sync[2:0] == TPD_MODE_CLOCK);
    property p_var_range;
        var_half >= 8'(TPD_VAR_HALF_MIN) && var_half <= 8'(TPD_VAR_HALF_MAX);
    endproperty
    a_var_range: assert property (p_var_range) else $error("pin 2 half period out of band");

    c_sw: cover property (sel_write);
    c_clock_run: cover property (clock_mode && running);
endmodule : tpd_top

// ### dv/tpd_board.sv
`timescale 1ns/1ps
module tpd_board
    import tpd_pkg::*;
(
    // jumpers fitted on the board
    input wire logic [7:0] jumper,
    // device pin drive
    input wire logic [7:0] drive,
    input wire logic [7:0] drive_en,
    // level seen on the pins
    output logic [7:0] level
);
    logic [7:0] pulled;
    // only the three low test points get a jumper to a pull-up
    assign pulled = {5'h00, jumper[2:0]};
    // internal pull-downs win where nothing drives and no jumper is fitted
    assign level = (drive & drive_en) | (pulled & ~drive_en);
endmodule : tpd_board

// ### dv/tpd_top_bench.sv
`timescale 1ns/1ps
module tpd_top_bench;
    import tpd_pkg::*;
    typedef struct packed {
        logic [2:0] what;
        logic [7:0] want;
        logic [7:0] mask;
    } tpd_note_type;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [7:0] jumper = 8'h00;
    logic [7:0] pin_level, DEBUG_TEST_POINT_OUT, DEBUG_TEST_POINT_OE, STRAP_VALUE;
    logic STRAP_VALID;
    tpd_sel_type SEL = '0;
    tpd_note_type notes[$];
    tpd_note_type n;
    logic [7:0] got, exp_oe, exp_out, known, last;
    logic [7:0] cnt [3];
    int mismatches = 0;
    int checks_done = 0;
    int i;
    event look;

    initial forever #5 CLK = ~CLK;

    tpd_board board (.jumper(jumper), .drive(DEBUG_TEST_POINT_OUT),
        .drive_en(DEBUG_TEST_POINT_OE), .level(pin_level));
    tpd_top dut (.CLK(CLK), .RESET_N(RESET_N), .DEBUG_TEST_POINT_IN(pin_level),
        .DEBUG_TEST_POINT_OUT(DEBUG_TEST_POINT_OUT), .DEBUG_TEST_POINT_OE(DEBUG_TEST_POINT_OE),
        .SEL(SEL), .STRAP_VALUE(STRAP_VALUE), .STRAP_VALID(STRAP_VALID));

    task automatic tally_and_finish();
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    task automatic note(input logic [2:0] what, input logic [7:0] want, input logic [7:0] mask);
        notes.push_back('{what, want, mask});
        -> look;
    endtask : note

    always @(look)
    begin
        while (notes.size() > 0)
        begin
            n = notes.pop_front();
            case (n.what)
                3'h0: got = DEBUG_TEST_POINT_OE;
                3'h1: got = DEBUG_TEST_POINT_OUT;
                3'h2: got = STRAP_VALUE;
                3'h3: got = {7'h00, STRAP_VALID};
                default: got = cnt[n.what - 3'h4];
            endcase
            checks_done++;
            if ((got & n.mask) !== (n.want & n.mask))
            begin
                mismatches++;
                $display("BAD %0t got %h want %h", $time, got & n.mask, n.want & n.mask);
            end
        end
    end

    task automatic reset_with(input logic [7:0] straps);
        @(posedge CLK);
        jumper <= straps;
        RESET_N <= 1'b0;
        repeat (8) @(posedge CLK);
        #1 note(3'h0, 8'h00, 8'hff);
        @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge CLK);
        #1 note(3'h3, 8'h00, 8'h01);
        @(posedge CLK);
        #1 note(3'h3, 8'h01, 8'h01);
        note(3'h2, straps & 8'h07, 8'hff);
    endtask : reset_with

    task automatic count_edges();
        cnt = '{8'h00, 8'h00, 8'h00};
        // let every divider settle; 12 edges then span whole half periods of all three
        repeat (4) @(posedge CLK);
        #1;
        last = DEBUG_TEST_POINT_OUT;
        repeat (12)
        begin
            @(posedge CLK);
            #1;
            cnt[0] += 8'(DEBUG_TEST_POINT_OUT[0] != last[0]);
            cnt[1] += 8'(DEBUG_TEST_POINT_OUT[2] != last[2]);
            cnt[2] += 8'(DEBUG_TEST_POINT_OUT[7] != last[7]);
            last = DEBUG_TEST_POINT_OUT;
        end
    endtask : count_edges

    task automatic select(input logic [7:0] mask, input tpd_src_type src, input logic [7:0] half);
        @(posedge CLK);
        SEL <= '{1'b1, mask, src, half};
        @(posedge CLK);
        SEL <= '0;
        repeat (2) @(posedge CLK);
        #1;
        exp_oe = (src == TPD_SRC_HIZ) ? (exp_oe & ~mask) : (exp_oe | mask);
        exp_out = (src == TPD_SRC_HIGH) ? (exp_out | mask) : (exp_out & ~mask);
        known = (src == TPD_SRC_LOW || src == TPD_SRC_HIGH) ? (known | mask) : (known & ~mask);
    endtask : select

    initial
    begin
        void'($urandom(32'h1324));
        reset_with(8'h00);
        note(3'h0, 8'h00, 8'hff);
        @(posedge CLK);
        jumper <= 8'h02;
        repeat (5) @(posedge CLK);
        #1 note(3'h2, 8'h00, 8'hff);
        note(3'h0, 8'h00, 8'hff);
        reset_with(8'h05);
        note(3'h0, 8'h00, 8'hff);
        reset_with(8'h02);
        note(3'h0, 8'hfd, 8'hff);
        note(3'h1, 8'h68, 8'h78);
        count_edges();
        note(3'h4, 8'(12 / TPD_FAST_HALF), 8'hff);
        note(3'h5, 8'(12 / TPD_VAR_HALF_RESET), 8'hff);
        note(3'h6, 8'(12 / TPD_SLOW_HALF), 8'hff);
        exp_oe = 8'hfd;
        exp_out = 8'h68;
        known = 8'h78;
        select(8'h00, TPD_SRC_HIZ, 8'h06);
        count_edges();
        note(3'h5, 8'h02, 8'hff);
        for (i = 0; i < 8; i++)
        begin
            select(8'($urandom), tpd_src_type'(i % 4), i[0] ? 8'hff : 8'h00);
            note(3'h0, exp_oe, 8'hff);
            note(3'h1, exp_out, known);
        end
        tally_and_finish();
    end

    initial
    begin
        #20000;
        mismatches++;
        tally_and_finish();
    end
endmodule : tpd_top_bench
